// ---- cpuag_map.svh ----
// Purpose: offsets, field positions, reset values and steps for the
//          cpu register and address generation block
// Assumes: included by bare name
// Notes:   definitions only
`ifndef CPUAG_MAP_SVH
`define CPUAG_MAP_SVH
`define CPUAG_VEC_RESET 16'h0000
`define CPUAG_ABS8_PAGE 8'hFF
`define CPUAG_MEMIND_PAGE 8'h00
`define CPUAG_SP_IDX 3'h7
`define CPUAG_STEP_BYTE 16'h0001
`define CPUAG_STEP_WORD 16'h0002
`define CPUAG_FLG_I 7
`define CPUAG_FLG_U1 6
`define CPUAG_FLG_H 5
`define CPUAG_FLG_U0 4
`define CPUAG_FLG_N 3
`define CPUAG_FLG_Z 2
`define CPUAG_FLG_V 1
`define CPUAG_FLG_C 0
`define CPUAG_FLG_I_RST 1'b1
`endif

// ---- cpuag_pkg.sv ----
// Purpose: types of the cpu register and address generation block
// Assumes: used with cpuag_map.svh
// Notes:   enums carry no explicit codes
package cpuag_pkg;
   typedef enum logic [3:0]
   {
      AM_REG, AM_IND, AM_DISP, AM_POSTINC, AM_PREDEC, AM_ABS8, AM_ABS16,
      AM_IMM8, AM_IMM16, AM_STEP, AM_PCREL, AM_MEMIND
   } cpuag_mode_t;
   typedef enum logic [2:0]
   {
      CO_EA, CO_REG_WR, CO_JUMP, CO_CALL, CO_PUSH_FLAGS, CO_POP_FLAGS
   } cpuag_cmd_t;
   typedef enum logic [2:0]
   {
      FOP_ADD, FOP_SUB, FOP_LOGIC, FOP_SHIFT, FOP_BIT, FOP_LDC, FOP_AND_FLAGS_INSTR,
      FOP_ORC_XOR
   } cpuag_fop_t;
   typedef enum logic [2:0]
   {
      ST_VEC, ST_IDLE, ST_CALC, ST_RD_TGT, ST_WR_STK, ST_RD_FLG
   } cpuag_state_t;
endpackage

// ---- cpuag_regfile.sv ----
// Purpose: eight word general registers, byte-lane writable
// Assumes: one write port, one registered read port
// Notes:   no reset, contents undefined until written
`timescale 1ns/1ps
`include "cpuag_map.svh"
module cpuag_regfile #(parameter int unsigned NREGS = 8,
   parameter int unsigned WIDTH = 16)
(
   input wire logic clk_in,
   input wire logic [2:0] rd_idx_in,
   output logic [WIDTH-1:0] rd_data_out,
   input wire logic wr_en_in,
   input wire logic [2:0] wr_idx_in,
   input wire logic [1:0] wr_be_in,
   input wire logic [WIDTH-1:0] wr_data_in,
   output logic [WIDTH-1:0] sp_out
);
   if (NREGS != 8 || WIDTH != 16)
   begin : g_chk
      $error("cpuag_regfile serves eight 16-bit registers only");
   end

   // each byte lane keeps its own storage, one writer per lane
   for (genvar b = 0; b < 2; b++)
   begin : g_lane
      logic [7:0] lane_q [NREGS];
      logic [7:0] rd_lane_q;
      always_ff @(posedge clk_in)
      begin
         if (wr_en_in && wr_be_in[b])
         begin
            lane_q[wr_idx_in] <= wr_data_in[b*8 +: 8];
         end
      end
      always_ff @(posedge clk_in)
      begin
         rd_lane_q <= lane_q[rd_idx_in];
      end
      assign rd_data_out[b*8 +: 8] = rd_lane_q;
      assign sp_out[b*8 +: 8] = lane_q[`CPUAG_SP_IDX];
   end
endmodule

// ---- cpuag_core.sv ----
// Purpose: programmer state, flag update and operand addressing
// Assumes: decoder, flag source and memory share clk_in
// Notes:   memory handshake holds mem_req_out until mem_ack_in
//
// Contract
// - eight word registers, sixteen byte halves
// - address registers always read full word
// - register seven is the stack pointer
// - word program counter, bit zero forced zero
// - mask bit blocks maskable interrupts, set
// - two user flag bits freely software writable
// - half carry from bit three or eleven
// - negative flag copies result sign bit
// - zero flag set on zero result
// - overflow flag on signed overflow only
// - carry from add, shift, or bit accumulator
// - reset loads vector, sets mask only
// - post-increment uses address then add_step_instr step
// - pre-decrement subtracts step then uses address
// - displacement add_step_instr second word to register
// - short absolute address lies in top page
// - immediates from extension, step of one/two
// - relative target is sign-extended byte plus counter
// - memory indirect reads target from page zero
// - odd word or branch address rounds down
// - bit operands by register, indirect, short absolute
// - register operands byte unless word instruction
// - pushed flags doubled, popped lower byte dropped
`timescale 1ns/1ps
`include "cpuag_map.svh"
module cpuag_core import cpuag_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic cmd_valid_in,
   input wire cpuag_cmd_t cmd_op_in,
   input wire cpuag_mode_t cmd_mode_in,
   input wire logic cmd_word_in,
   input wire logic [3:0] cmd_reg_in,
   input wire logic [15:0] cmd_ext_in,
   output logic cmd_ready_out,
   output logic done_out,
   output logic [15:0] ea_out,
   output logic [15:0] opnd_out,
   input wire logic pc_inc_in,
   output logic [15:0] pc_out,
   output logic [15:0] sp_out,
   input wire logic flg_valid_in,
   input wire cpuag_fop_t flg_op_in,
   input wire logic flg_word_in,
   input wire logic [15:0] flg_a_in,
   input wire logic [15:0] flg_b_in,
   input wire logic flg_cin_in,
   output logic [7:0] flags_out,
   input wire logic irq_in,
   input wire logic nmi_in,
   input wire logic int_entry_in,
   output logic int_take_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [15:0] mem_addr_out,
   output logic [15:0] mem_wdata_out,
   input wire logic [15:0] mem_rdata_in,
   input wire logic mem_ack_in
);
   cpuag_state_t state_q;
   cpuag_cmd_t op_q;
   cpuag_mode_t mode_q;
   logic word_q, done_q, ready_q, take_q, flg_i_q;
   logic [3:0] reg_q;
   logic [15:0] ext_q, tgt_q, pc_q, ea_q, opnd_q;
   logic mem_req_q, mem_we_q;
   logic [15:0] mem_addr_q, mem_wdata_q;
   logic [6:0] flg_rest_q;
   logic [7:0] condition_flags, ccr_d;
   logic [15:0] rf_rd_data, sp, step, ea_d, opnd_d, rf_wdata, rd_tgt;
   logic rf_wr_en;
   logic [2:0] rf_widx;
   logic [1:0] rf_be;

   cpuag_regfile #(.NREGS(8), .WIDTH(16)) u_regs
   (
      .clk_in(clk_in),
      .rd_idx_in(cmd_reg_in[2:0]),
      .rd_data_out(rf_rd_data),
      .wr_en_in(rf_wr_en),
      .wr_idx_in(rf_widx),
      .wr_be_in(rf_be),
      .wr_data_in(rf_wdata),
      .sp_out(sp)
   );

   assign condition_flags = {flg_i_q, flg_rest_q};
   assign step = word_q ? `CPUAG_STEP_WORD : `CPUAG_STEP_BYTE;
   assign rd_tgt = {mem_rdata_in[15:1], 1'b0};

   // operand and address per mode from register, extension, step or counter
   always_comb
   begin
      ea_d = rf_rd_data;
      opnd_d = 16'h0000;
      case (mode_q)
         AM_REG: opnd_d = word_q ? rf_rd_data : (reg_q[3] ?
            {8'h00, rf_rd_data[7:0]} : {8'h00, rf_rd_data[15:8]});
         AM_IND: ea_d = rf_rd_data;
         AM_DISP: ea_d = rf_rd_data + ext_q;
         AM_POSTINC: ea_d = rf_rd_data;
         AM_PREDEC: ea_d = rf_rd_data - step;
         AM_ABS8: ea_d = {`CPUAG_ABS8_PAGE, ext_q[7:0]};
         AM_ABS16: ea_d = ext_q;
         AM_IMM8: opnd_d = {8'h00, ext_q[7:0]};
         AM_IMM16: opnd_d = ext_q;
         AM_STEP: opnd_d = step;
         AM_PCREL: ea_d = pc_q + {{8{ext_q[7]}}, ext_q[7:0]};
         AM_MEMIND: ea_d = {`CPUAG_MEMIND_PAGE, ext_q[7:0]};
         default: ea_d = rf_rd_data;
      endcase
      if (word_q || op_q == CO_JUMP || op_q == CO_CALL)
      begin
         ea_d[0] = 1'b0;
      end
   end

   // register write port, byte lanes
   always_comb
   begin
      rf_wr_en = 1'b0;
      rf_widx = reg_q[2:0];
      rf_be = 2'b11;
      rf_wdata = 16'h0000;
      if (state_q == ST_CALC && op_q == CO_EA &&
         (mode_q == AM_POSTINC || mode_q == AM_PREDEC))
      begin
         rf_wr_en = 1'b1;
         rf_wdata = (mode_q == AM_POSTINC) ? rf_rd_data + step :
            rf_rd_data - step;
      end
      else if (state_q == ST_CALC && op_q == CO_REG_WR)
      begin
         rf_wr_en = 1'b1;
         rf_be = word_q ? 2'b11 : (reg_q[3] ? 2'b01 : 2'b10);
         rf_wdata = word_q ? ext_q : {ext_q[7:0], ext_q[7:0]};
      end
      else if (state_q == ST_WR_STK && mem_ack_in)
      begin
         rf_wr_en = 1'b1;
         rf_widx = `CPUAG_SP_IDX;
         rf_wdata = mem_addr_q;
      end
      else if (state_q == ST_RD_FLG && mem_ack_in)
      begin
         rf_wr_en = 1'b1;
         rf_widx = `CPUAG_SP_IDX;
         rf_wdata = mem_addr_q + `CPUAG_STEP_WORD;
      end
   end

   // command sequencer and memory requests
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_q <= ST_VEC;
         mem_req_q <= 1'b1;
         mem_we_q <= 1'b0;
         mem_addr_q <= `CPUAG_VEC_RESET;
         mem_wdata_q <= 16'h0000;
         pc_q <= 16'h0000;
         done_q <= 1'b0;
         ready_q <= 1'b0;
         op_q <= CO_EA;
         mode_q <= AM_REG;
         word_q <= 1'b0;
         reg_q <= 4'h0;
         ext_q <= 16'h0000;
         tgt_q <= 16'h0000;
         ea_q <= 16'h0000;
         opnd_q <= 16'h0000;
      end
      else
      begin
         done_q <= 1'b0;
         case (state_q)
            ST_VEC:
               if (mem_ack_in)
               begin
                  pc_q <= rd_tgt;
                  mem_req_q <= 1'b0;
                  ready_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            ST_IDLE:
               if (cmd_valid_in)
               begin
                  op_q <= cmd_op_in;
                  mode_q <= cmd_mode_in;
                  word_q <= cmd_word_in;
                  reg_q <= cmd_reg_in;
                  ext_q <= cmd_ext_in;
                  ready_q <= 1'b0;
                  state_q <= ST_CALC;
               end
               else if (pc_inc_in)
               begin
                  pc_q <= {pc_q[15:1] + 15'h0001, 1'b0};
               end
            ST_CALC:
               case (op_q)
                  CO_JUMP, CO_CALL:
                     if (mode_q == AM_MEMIND)
                     begin
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b0;
                        mem_addr_q <= ea_d;
                        state_q <= ST_RD_TGT;
                     end
                     else if (op_q == CO_CALL)
                     begin
                        tgt_q <= ea_d;
                        mem_req_q <= 1'b1;
                        mem_we_q <= 1'b1;
                        mem_addr_q <= {sp[15:1], 1'b0} - `CPUAG_STEP_WORD;
                        mem_wdata_q <= pc_q;
                        state_q <= ST_WR_STK;
                     end
                     else
                     begin
                        pc_q <= ea_d;
                        done_q <= 1'b1;
                        ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                     end
                  CO_PUSH_FLAGS:
                  begin
                     mem_req_q <= 1'b1;
                     mem_we_q <= 1'b1;
                     mem_addr_q <= {sp[15:1], 1'b0} - `CPUAG_STEP_WORD;
                     mem_wdata_q <= {condition_flags, condition_flags};
                     state_q <= ST_WR_STK;
                  end
                  CO_POP_FLAGS:
                  begin
                     mem_req_q <= 1'b1;
                     mem_we_q <= 1'b0;
                     mem_addr_q <= {sp[15:1], 1'b0};
                     state_q <= ST_RD_FLG;
                  end
                  default:
                  begin
                     ea_q <= ea_d;
                     opnd_q <= opnd_d;
                     done_q <= 1'b1;
                     ready_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end
               endcase
            ST_RD_TGT:
               if (mem_ack_in)
               begin
                  if (op_q == CO_CALL)
                  begin
                     tgt_q <= rd_tgt;
                     mem_we_q <= 1'b1;
                     mem_addr_q <= {sp[15:1], 1'b0} - `CPUAG_STEP_WORD;
                     mem_wdata_q <= pc_q;
                     state_q <= ST_WR_STK;
                  end
                  else
                  begin
                     pc_q <= rd_tgt;
                     mem_req_q <= 1'b0;
                     done_q <= 1'b1;
                     ready_q <= 1'b1;
                     state_q <= ST_IDLE;
                  end
               end
            ST_WR_STK, ST_RD_FLG:
               if (mem_ack_in)
               begin
                  if (op_q == CO_CALL)
                  begin
                     pc_q <= tgt_q;
                  end
                  mem_req_q <= 1'b0;
                  mem_we_q <= 1'b0;
                  done_q <= 1'b1;
                  ready_q <= 1'b1;
                  state_q <= ST_IDLE;
               end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // next flag value from the flag port
   always_comb
   begin
      logic [8:0] s9;
      logic [16:0] s17;
      logic [4:0] h5;
      logic [12:0] h13;
      logic sub, rm, am, bm;
      s9 = 9'h000;
      s17 = 17'h00000;
      h5 = 5'h00;
      h13 = 13'h0000;
      sub = (flg_op_in == FOP_SUB);
      ccr_d = condition_flags;
      if (sub)
      begin
         s9 = {1'b0, flg_a_in[7:0]} - {1'b0, flg_b_in[7:0]} -
            {8'h00, flg_cin_in};
         s17 = {1'b0, flg_a_in} - {1'b0, flg_b_in} - {16'h0000, flg_cin_in};
         h5 = {1'b0, flg_a_in[3:0]} - {1'b0, flg_b_in[3:0]} -
            {4'h0, flg_cin_in};
         h13 = {1'b0, flg_a_in[11:0]} - {1'b0, flg_b_in[11:0]};
      end
      else
      begin
         s9 = {1'b0, flg_a_in[7:0]} + {1'b0, flg_b_in[7:0]} +
            {8'h00, flg_cin_in};
         s17 = {1'b0, flg_a_in} + {1'b0, flg_b_in} + {16'h0000, flg_cin_in};
         h5 = {1'b0, flg_a_in[3:0]} + {1'b0, flg_b_in[3:0]} +
            {4'h0, flg_cin_in};
         h13 = {1'b0, flg_a_in[11:0]} + {1'b0, flg_b_in[11:0]};
      end
      rm = flg_word_in ? s17[15] : s9[7];
      am = flg_word_in ? flg_a_in[15] : flg_a_in[7];
      bm = flg_word_in ? flg_b_in[15] : flg_b_in[7];
      case (flg_op_in)
         FOP_ADD, FOP_SUB:
         begin
            ccr_d[`CPUAG_FLG_H] = flg_word_in ? h13[12] : h5[4];
            ccr_d[`CPUAG_FLG_N] = rm;
            ccr_d[`CPUAG_FLG_Z] = flg_word_in ? (s17[15:0] == 16'h0000) :
               (s9[7:0] == 8'h00);
            ccr_d[`CPUAG_FLG_V] = (sub ? (am != bm) : (am == bm)) &&
               (rm != am);
            ccr_d[`CPUAG_FLG_C] = flg_word_in ? s17[16] : s9[8];
         end
         FOP_LOGIC, FOP_SHIFT:
         begin
            ccr_d[`CPUAG_FLG_N] = am;
            ccr_d[`CPUAG_FLG_Z] = flg_word_in ? (flg_a_in == 16'h0000) :
               (flg_a_in[7:0] == 8'h00);
            ccr_d[`CPUAG_FLG_V] = 1'b0;
            if (flg_op_in == FOP_SHIFT)
            begin
               ccr_d[`CPUAG_FLG_C] = flg_cin_in;
            end
         end
         FOP_BIT: ccr_d[`CPUAG_FLG_C] = flg_cin_in;
         FOP_LDC: ccr_d = flg_a_in[7:0];
         FOP_AND_FLAGS_INSTR: ccr_d = condition_flags & flg_a_in[7:0];
         default: ccr_d = flg_b_in[0] ? (condition_flags ^ flg_a_in[7:0]) :
            (condition_flags | flg_a_in[7:0]);
      endcase
   end

   // lower seven flags carry no reset
   always_ff @(posedge clk_in)
   begin
      if (state_q == ST_RD_FLG && mem_ack_in)
      begin
         flg_rest_q <= mem_rdata_in[14:8];
      end
      else if (flg_valid_in)
      begin
         flg_rest_q <= ccr_d[6:0];
      end
   end

   // mask bit: reset wins over all, entry wins over pop and flag port
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         flg_i_q <= `CPUAG_FLG_I_RST;
         take_q <= 1'b0;
      end
      else
      begin
         if (int_entry_in)
         begin
            flg_i_q <= 1'b1;
         end
         else if (state_q == ST_RD_FLG && mem_ack_in)
         begin
            flg_i_q <= mem_rdata_in[15];
         end
         else if (flg_valid_in)
         begin
            flg_i_q <= ccr_d[`CPUAG_FLG_I];
         end
         take_q <= nmi_in || (irq_in && !flg_i_q);
      end
   end

   assign cmd_ready_out = ready_q;
   assign done_out = done_q;
   assign ea_out = ea_q;
   assign opnd_out = opnd_q;
   assign pc_out = pc_q;
   assign sp_out = sp;
   assign flags_out = condition_flags;
   assign int_take_out = take_q;
   assign mem_req_out = mem_req_q;
   assign mem_we_out = mem_we_q;
   assign mem_addr_out = mem_addr_q;
   assign mem_wdata_out = mem_wdata_q;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   AST_PC_EVEN: assert property (pc_q[0] == 1'b0)
      else $error("program counter odd");
   AST_MASK_VEC: assert property (state_q == ST_VEC |->
      flg_i_q) else $error("mask clear during vector fetch");
   AST_ENTRY_MASK: assert property (int_entry_in |=> flg_i_q)
      else $error("mask not set on entry");
   AST_MASKED: assert property (take_q && !$past(nmi_in) |->
      !$past(flg_i_q)) else $error("masked interrupt taken");
   AST_ABS8: assert property (done_q && mode_q == AM_ABS8 &&
      op_q == CO_EA |-> ea_q[15:8] == 8'hFF) else $error("abs8 off page");
   AST_MEMIND: assert property (state_q == ST_RD_TGT &&
      !mem_we_q |-> mem_addr_q[15:8] == 8'h00 && !mem_addr_q[0])
      else $error("indirect read off page zero");
   AST_POSTINC: assert property (state_q == ST_CALC &&
      op_q == CO_EA && mode_q == AM_POSTINC |=> ea_q == $past(rf_rd_data) &&
      $past(rf_wdata) - ea_q == step) else $error("post-increment wrong");
   AST_PREDEC: assert property (state_q == ST_CALC &&
      op_q == CO_EA && mode_q == AM_PREDEC |=>
      $past(rf_rd_data) - ea_q == step &&
      ea_q == $past(rf_wdata)) else $error("pre-decrement wrong");
   AST_PUSH_FLAGS: assert property (state_q == ST_WR_STK &&
      op_q == CO_PUSH_FLAGS |-> mem_wdata_q[15:8] == mem_wdata_q[7:0])
      else $error("pushed flags not doubled");
   AST_ZERO_LOGIC: assert property (flg_valid_in &&
      flg_op_in == FOP_LOGIC && !flg_word_in && !int_entry_in &&
      state_q != ST_RD_FLG |=>
      flags_out[2] == ($past(flg_a_in[7:0]) == 8'h00) &&
      flags_out[3] == $past(flg_a_in[7])) else $error("zero flag wrong");
   AST_HALF_BYTE: assert property (flg_valid_in &&
      flg_op_in == FOP_ADD && !flg_word_in && state_q != ST_RD_FLG |=>
      flags_out[5] ==
      ($past({1'b0, flg_a_in[3:0]} + {1'b0, flg_b_in[3:0]} +
      {4'h0, flg_cin_in}) > 5'h0F)) else $error("half carry wrong");

   COV_VEC: cover property (state_q == ST_VEC ##1 state_q == ST_IDLE);
   COV_CALL_IND: cover property (op_q == CO_CALL && state_q == ST_RD_TGT
      ##[1:8] done_q);
   COV_PUSH: cover property (op_q == CO_PUSH_FLAGS && done_q);
   COV_POSTINC: cover property (mode_q == AM_POSTINC && done_q);
endmodule

// ---- cpuag_mem_model.sv ----
// Purpose: word memory on the far side of the core's memory handshake
// Assumes: one request at a time, held until the ack edge
// Notes:   lat_in sets wait cycles before each ack
`timescale 1ns/1ps
module cpuag_mem_model
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] lat_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   output logic [15:0] rdata_out,
   output logic ack_out
);
   logic [15:0] mem [0:32767];
   logic [3:0] wait_q;
   logic hit;
   assign hit = req_in && !ack_out && (wait_q >= lat_in);
   // ack and read data; read lines scramble outside an ack
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ack_out <= 1'b0;
         wait_q <= 4'h0;
         rdata_out <= 16'h5A5A;
      end
      else
      begin
         ack_out <= hit;
         rdata_out <= hit ? mem[addr_in[15:1]] : ~rdata_out;
         if (!req_in || ack_out)
            wait_q <= 4'h0;
         else if (wait_q != 4'hF)
            wait_q <= wait_q + 4'h1;
      end
   end
   // plain always so the bench may preload words
   always @(posedge clk_in)
   begin
      if (rst_n_in && hit && we_in)
         mem[addr_in[15:1]] <= wdata_in;
   end
endmodule

// ---- test_cpuag_core.sv ----
// Purpose: self-checking bench of the register and addressing core
// Assumes: memory model answers the core's memory handshake
// Notes:   inputs move 1 ns after the rising edge
`timescale 1ns/1ps
module test_cpuag_core import cpuag_pkg::*;;
   logic clk_in = 1'b0, rst_n_in = 1'b0, cmd_valid_in = 1'b0;
   cpuag_cmd_t cmd_op_in = CO_EA;
   cpuag_mode_t cmd_mode_in = AM_REG;
   logic cmd_word_in = 1'b0, cmd_ready_out, done_out, pc_inc_in = 1'b0;
   logic [3:0] cmd_reg_in = 4'h0, lat = 4'h0;
   logic [15:0] cmd_ext_in = 16'h0000, ea_out, opnd_out, pc_out, sp_out;
   logic flg_valid_in = 1'b0, flg_word_in = 1'b0, flg_cin_in = 1'b0;
   cpuag_fop_t flg_op_in = FOP_ADD;
   logic [15:0] flg_a_in = 16'h0000, flg_b_in = 16'h0000;
   logic [7:0] flags_out;
   logic irq_in = 1'b0, nmi_in = 1'b0, int_entry_in = 1'b0, int_take_out;
   logic mem_req_out, mem_we_out, mem_ack_in;
   logic [15:0] mem_addr_out, mem_wdata_out, mem_rdata_in;
   int errors = 0, tests_run = 0;
   always #10 clk_in = ~clk_in;
   cpuag_core cpuag_core_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
      .cmd_mode_in(cmd_mode_in), .cmd_word_in(cmd_word_in),
      .cmd_reg_in(cmd_reg_in), .cmd_ext_in(cmd_ext_in),
      .cmd_ready_out(cmd_ready_out), .done_out(done_out), .ea_out(ea_out),
      .opnd_out(opnd_out), .pc_inc_in(pc_inc_in), .pc_out(pc_out),
      .sp_out(sp_out), .flg_valid_in(flg_valid_in), .flg_op_in(flg_op_in),
      .flg_word_in(flg_word_in), .flg_a_in(flg_a_in), .flg_b_in(flg_b_in),
      .flg_cin_in(flg_cin_in), .flags_out(flags_out), .irq_in(irq_in),
      .nmi_in(nmi_in), .int_entry_in(int_entry_in),
      .int_take_out(int_take_out), .mem_req_out(mem_req_out),
      .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out),
      .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in),
      .mem_ack_in(mem_ack_in));
   cpuag_mem_model cpuag_mem_model_i (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .lat_in(lat), .req_in(mem_req_out), .we_in(mem_we_out),
      .addr_in(mem_addr_out), .wdata_in(mem_wdata_out),
      .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic rdy;
      int n = 0;
      while (cmd_ready_out !== 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
      if (n >= 300)
      begin
         errors++;
         print_verdict();
      end
   endtask
   task automatic cmd(input cpuag_cmd_t op, input cpuag_mode_t md,
      input logic w, input logic [3:0] r, input logic [15:0] x);
      int n = 0;
      rdy();
      cmd_op_in = op;
      cmd_mode_in = md;
      cmd_word_in = w;
      cmd_reg_in = r;
      cmd_ext_in = x;
      cmd_valid_in = 1'b1;
      tick(1);
      cmd_valid_in = 1'b0;
      while (done_out !== 1'b1 && n < 300)
      begin
         tick(1);
         n++;
      end
      if (n >= 300)
      begin
         errors++;
         print_verdict();
      end
   endtask
   // k: 0 no check, 1 effective address, 2 operand
   task automatic ea(input cpuag_cmd_t op, input cpuag_mode_t md,
      input logic w, input logic [3:0] r, input logic [15:0] x,
      input logic [1:0] k, input logic [15:0] e);
      cmd(op, md, w, r, x);
      if (k == 2'h1)
         chk(ea_out, e);
      else if (k == 2'h2)
         chk(opnd_out, e);
   endtask
   task automatic fl(input cpuag_fop_t op, input logic w,
      input logic [15:0] a, input logic [15:0] b, input logic c,
      input logic [7:0] m, input logic [7:0] e);
      flg_op_in = op;
      flg_word_in = w;
      flg_a_in = a;
      flg_b_in = b;
      flg_cin_in = c;
      flg_valid_in = 1'b1;
      tick(1);
      flg_valid_in = 1'b0;
      chk({8'h00, flags_out & m}, {8'h00, e});
   endtask
   initial
   begin
      cpuag_mem_model_i.mem[0] = 16'h0101;
      cpuag_mem_model_i.mem[16'h0020] = 16'h0301;
      tick(1);
      chk({8'h00, flags_out[7], 7'h00}, 16'h0080);
      chk(pc_out, 16'h0000);
      chk({mem_req_out, mem_addr_out[14:0]}, 16'h8000);
      tick(1);
      rst_n_in = 1'b1;
      rdy();
      chk(pc_out, 16'h0100);
      pc_inc_in = 1'b1;
      tick(1);
      pc_inc_in = 1'b0;
      chk(pc_out, 16'h0102);
      ea(CO_REG_WR, AM_REG, 1, 4'h7, 16'h0200, 0, 0);
      chk(sp_out, 16'h0200);
      ea(CO_REG_WR, AM_REG, 1, 4'h2, 16'h1000, 0, 0);
      ea(CO_REG_WR, AM_REG, 1, 4'h3, 16'h1200, 0, 0);
      ea(CO_REG_WR, AM_REG, 0, 4'hB, 16'h00CD, 0, 0);
      ea(CO_EA, AM_REG, 1, 4'h3, 0, 2, 16'h12CD);
      ea(CO_REG_WR, AM_REG, 0, 4'h3, 16'h0077, 0, 0);
      ea(CO_EA, AM_REG, 1, 4'h3, 0, 2, 16'h77CD);
      ea(CO_EA, AM_IND, 0, 4'hB, 0, 1, 16'h77CD);
      ea(CO_EA, AM_POSTINC, 1, 4'h2, 0, 1, 16'h1000);
      ea(CO_EA, AM_POSTINC, 0, 4'h2, 0, 1, 16'h1002);
      ea(CO_EA, AM_IND, 0, 4'h2, 0, 1, 16'h1003);
      ea(CO_EA, AM_PREDEC, 0, 4'h2, 0, 1, 16'h1002);
      ea(CO_EA, AM_PREDEC, 1, 4'h2, 0, 1, 16'h1000);
      ea(CO_EA, AM_DISP, 0, 4'h2, 16'h0011, 1, 16'h1011);
      ea(CO_EA, AM_DISP, 1, 4'h2, 16'h0011, 1, 16'h1010);
      ea(CO_EA, AM_ABS8, 0, 4'h0, 16'h0034, 1, 16'hFF34);
      ea(CO_EA, AM_ABS16, 0, 4'h0, 16'h4567, 1, 16'h4567);
      ea(CO_EA, AM_IMM8, 0, 4'h0, 16'h00AB, 2, 16'h00AB);
      ea(CO_EA, AM_IMM16, 1, 4'h0, 16'hBEEF, 2, 16'hBEEF);
      ea(CO_EA, AM_STEP, 0, 4'h0, 0, 2, 16'h0001);
      ea(CO_EA, AM_STEP, 1, 4'h0, 0, 2, 16'h0002);
      ea(CO_EA, AM_PCREL, 0, 4'h0, 16'h00FE, 1, 16'h0100);
      ea(CO_EA, AM_PCREL, 0, 4'h0, 16'h0080, 1, 16'h0082);
      lat = 4'h3;
      cmd(CO_CALL, AM_MEMIND, 1, 4'h0, 16'h0041);
      chk(pc_out, 16'h0300);
      chk(cpuag_mem_model_i.mem[16'h00FF], 16'h0102);
      chk(sp_out, 16'h01FE);
      ea(CO_JUMP, AM_ABS16, 1, 4'h0, 16'h0457, 0, 0);
      chk(pc_out, 16'h0456);
      cmd(CO_JUMP, AM_MEMIND, 1, 4'h0, 16'h0040);
      chk(pc_out, 16'h0300);
      fl(FOP_ADD, 0, 16'h0F, 16'h01, 0, 8'h2F, 8'h20);
      fl(FOP_ADD, 0, 16'h7F, 16'h01, 0, 8'h2F, 8'h2A);
      fl(FOP_ADD, 0, 16'hFF, 16'h01, 0, 8'h2F, 8'h25);
      fl(FOP_ADD, 0, 16'h01, 16'h01, 1, 8'h2F, 8'h00);
      fl(FOP_SUB, 0, 16'h00, 16'h01, 0, 8'h2F, 8'h29);
      fl(FOP_ADD, 1, 16'h0800, 16'h0800, 0, 8'h2F, 8'h20);
      fl(FOP_SUB, 1, 16'h8000, 16'h0001, 0, 8'h2F, 8'h22);
      fl(FOP_SHIFT, 0, 16'h00, 16'h00, 1, 8'h0F, 8'h05);
      fl(FOP_BIT, 0, 16'h0000, 0, 1, 8'h01, 8'h01);
      fl(FOP_LDC, 0, 16'h00D0, 0, 0, 8'hFF, 8'hD0);
      fl(FOP_AND_FLAGS_INSTR, 0, 16'h0040, 0, 0, 8'hFF, 8'h40);
      fl(FOP_ORC_XOR, 0, 16'h0010, 0, 0, 8'hFF, 8'h50);
      fl(FOP_ORC_XOR, 0, 16'h0050, 1, 0, 8'hFF, 8'h00);
      irq_in = 1'b1;
      tick(2);
      chk({15'h0000, int_take_out}, 16'h0001);
      int_entry_in = 1'b1;
      tick(1);
      int_entry_in = 1'b0;
      tick(2);
      chk({15'h0000, int_take_out}, 16'h0000);
      nmi_in = 1'b1;
      tick(2);
      chk({15'h0000, int_take_out}, 16'h0001);
      nmi_in = 1'b0;
      irq_in = 1'b0;
      cmd(CO_PUSH_FLAGS, AM_REG, 1, 4'h7, 16'h0000);
      chk(cpuag_mem_model_i.mem[16'h00FE], 16'h8080);
      chk(sp_out, 16'h01FC);
      cpuag_mem_model_i.mem[16'h00FE] = 16'h5AA5;
      cmd(CO_POP_FLAGS, AM_REG, 1, 4'h7, 16'h0000);
      chk({8'h00, flags_out}, 16'h005A);
      chk(sp_out, 16'h01FE);
      cmd(CO_CALL, AM_PCREL, 0, 4'h0, 16'h0010);
      chk(pc_out, 16'h0310);
      chk(cpuag_mem_model_i.mem[16'h00FE], 16'h0300);
      chk(sp_out, 16'h01FC);
      print_verdict();
   end
endmodule
